/* rtl/tfsr_buf.sv */
// Purpose: Two-entry element buffer with valid and ready on both sides
// Assumes: Writer pushes only while space is shown
// Notes: space_next tells the writer the room after this edge
`timescale 1ns/1ps
module tfsr_buf #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic space_next,
   // Drain side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   typedef struct packed {
      logic [1:0][W-1:0] mem;
      logic [1:0] cnt;
      logic vld;
      logic rdy;
   } tfsr_buf_st_t;
   tfsr_buf_st_t s_reg, s_next;

   // Pop from head, push behind remaining entry
   always_comb begin
      s_next = s_reg;
      if (s_reg.vld && out_ready) begin
         s_next.mem[0] = s_reg.mem[1];
         s_next.cnt = s_reg.cnt - 2'd1;
      end
      if (in_valid && s_reg.rdy) begin
         s_next.mem[s_next.cnt[0]] = in_data;
         s_next.cnt = s_next.cnt + 2'd1;
      end
      s_next.vld = (s_next.cnt != 2'd0);
      s_next.rdy = (s_next.cnt != 2'd2);
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.rdy <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign in_ready = s_reg.rdy;
   assign space_next = s_next.rdy;
   assign out_valid = s_reg.vld;
   assign out_data = s_reg.mem[0];
endmodule

/* rtl/tfsr_pkg.sv */
// Purpose: Shared constants and types of the trace filter and resolver
// Assumes: One clock, APB register access, 32-bit data
// Notes: Sequence values run 0..Q-1, held in SEQ_W bits
package tfsr_pkg;
   // -----------------------------------------------------------------
   // Sizes
   // -----------------------------------------------------------------
   localparam int TAG_W = 3;
   localparam int NTAG = 8;
   localparam int SEQ_W = 5;
   localparam logic [4:0] Q_V = 5'h10;
   localparam int NCMP = 8;
   localparam int NRES = 4;
   localparam int NLVL = 7;
   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_SEL = 8'h04;
   localparam logic [7:0] OFF_SPEC = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0C;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int CTRL_INIT = 0;
   localparam int CTRL_SS = 1;
   localparam int CTRL_ESEL = 2;
   localparam int CTRL_ETYPE = 4;
   localparam int CTRL_EXCL = 5;
   localparam int SEL_SAC_START = 0;
   localparam int SEL_PE_START = 8;
   localparam int SEL_SAC_STOP = 16;
   localparam int SEL_PE_STOP = 24;
   localparam int STAT_X = 0;
   localparam int STAT_G = 8;
   localparam int STAT_OUT = 16;
   localparam int STAT_TV = 24;
   localparam int STAT_SMP = 28;
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [11:0] RST_CTRL = 12'h000;
   localparam logic [31:0] RST_SEL = 32'h0000_0000;
   localparam logic [4:0] RST_SPEC = 5'h0F;
   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [TAG_W-1:0] tag;
      logic has_p0;
      logic prohibited;
      logic debug;
      logic incl_ok;
      logic [2:0] level;
      logic [NCMP-1:0] sac_hit;
      logic [NCMP-1:0] pe_hit;
   } tfsr_blk_t;
   typedef struct packed {
      logic cancel;
      logic [TAG_W-1:0] tag;
   } tfsr_rs_t;
   typedef struct packed {
      logic blk;
      logic p0;
      logic [TAG_W-1:0] tag;
      logic [SEQ_W-1:0] commit_n;
      logic [SEQ_W-1:0] cancel_n;
   } tfsr_elem_t;
endpackage

/* rtl/tfsr_top.sv */
// Purpose: Speculation resolver and instruction view filter for one core
// Assumes: Core inputs are on pclk; software programs via APB
// Notes: Resolve or cancel is handled before a new block in one cycle
`timescale 1ns/1ps
// How it works
// - Init loads table and sequence with committed
// - Traced branch block advances sequence, stores mapping
// - Resolve youngest tag yields commit count
// - Cancel oldest tag yields cancel count
// - Outstanding speculation never exceeds configured depth
// - View is zero when prohibited or debug
// - While view high every instruction traced
// - View high anywhere traces whole block
// - View rising traces next branch element
// - May trace low-view branch revealing earlier
// - Target address need not be traced
// - Event select and type form resource term
// - Resource input sampled when block processed
// - No sampling in cycles without blocks
// - Level term is inverse of exclude bit
// - Enabled comparator match marks start point
// - Start/stop term and state update equation
module tfsr_top
   import tfsr_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Instruction blocks from the core
   input wire logic blk_valid,
   input wire tfsr_blk_t blk,
   input wire logic [NRES-1:0] res_in,
   output logic blk_ready,
   // Resolve and cancel from the core
   input wire logic rs_valid,
   input wire tfsr_rs_t rs,
   output logic rs_ready,
   // Elements to trace generation
   output logic elem_valid,
   output tfsr_elem_t elem,
   input wire logic elem_ready,
   // View status
   output logic trace_view
);
   // ---------------------------------------------------------------
   // Modulo-q arithmetic
   // ---------------------------------------------------------------
   function automatic logic [SEQ_W-1:0] mod_inc(input logic [SEQ_W-1:0] a);
      mod_inc = (a == Q_V - 5'h01) ? 5'h00 : a + 5'h01;
   endfunction

   function automatic logic [SEQ_W-1:0] mod_sub(input logic [SEQ_W-1:0] a,
                                                 input logic [SEQ_W-1:0] b);
      mod_sub = (a >= b) ? a - b : a + Q_V - b;
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [NTAG-1:0][SEQ_W-1:0] map;
      logic [SEQ_W-1:0] x;
      logic [SEQ_W-1:0] gamma;
      logic [SEQ_W-1:0] maxspec;
      logic [1:0] esel;
      logic etype;
      logic [NLVL-1:0] excl;
      logic ss;
      logic [31:0] sel;
      logic pend;
      logic tv;
      logic [NRES-1:0] sample;
      logic blk_ready;
      logic rs_ready;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } tfsr_st_t;
   tfsr_st_t s, n;

   logic acc_blk, acc_rs, wr, init_wr, start_hit, stop_hit, s_term;
   logic e_term, n_term, tv, traced, push, space_next;
   logic [SEQ_W-1:0] rs_map, commit_n, cancel_n;
   tfsr_elem_t push_d;

   // Handshakes and filter terms
   assign acc_blk = blk_valid && s.blk_ready;
   assign acc_rs = rs_valid && s.rs_ready;
   assign wr = psel && penable && s.pready && pwrite && !s.pslverr;
   assign init_wr = wr && paddr == OFF_CTRL && pwdata[CTRL_INIT];
   assign rs_map = s.map[rs.tag];
   assign start_hit = |(blk.sac_hit & s.sel[SEL_SAC_START +: NCMP])
                    | |(blk.pe_hit & s.sel[SEL_PE_START +: NCMP]);
   assign stop_hit = |(blk.sac_hit & s.sel[SEL_SAC_STOP +: NCMP])
                   | |(blk.pe_hit & s.sel[SEL_PE_STOP +: NCMP]);
   assign s_term = s.ss || start_hit;
   assign e_term = (blk.level < 3'd7) && !s.excl[blk.level];
   assign n_term = s.etype ? (res_in[s.esel] && res_in[s.esel ^ 2'd1])
                           : res_in[s.esel];
   assign tv = !(blk.prohibited || blk.debug)
             && s_term && blk.incl_ok && e_term && n_term;
   // Branch traced while view high or an earlier view is unrevealed
   assign traced = blk.has_p0 && (tv || s.pend);

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      n = s;
      commit_n = 5'h00;
      cancel_n = 5'h00;
      // APB answer one cycle after setup
      n.pready = psel && !penable;
      n.pslverr = 1'b0;
      if (psel && !penable) begin
         n.prdata = 32'h0000_0000;
         unique case (paddr)
            OFF_CTRL: begin
               n.prdata[CTRL_SS] = s.ss;
               n.prdata[CTRL_ESEL +: 2] = s.esel;
               n.prdata[CTRL_ETYPE] = s.etype;
               n.prdata[CTRL_EXCL +: NLVL] = s.excl;
            end
            OFF_SEL: n.prdata = s.sel;
            OFF_SPEC: n.prdata[SEQ_W-1:0] = s.maxspec;
            OFF_STAT: begin
               n.prdata[STAT_X +: SEQ_W] = s.x;
               n.prdata[STAT_G +: SEQ_W] = s.gamma;
               n.prdata[STAT_OUT +: SEQ_W] = mod_sub(s.x, s.gamma);
               n.prdata[STAT_TV] = s.tv;
               n.prdata[STAT_SMP +: NRES] = s.sample;
            end
            default: n.pslverr = 1'b1;
         endcase
      end
      // Register writes
      if (wr) begin
         unique case (paddr)
            OFF_CTRL: begin
               n.esel = pwdata[CTRL_ESEL +: 2];
               n.etype = pwdata[CTRL_ETYPE];
               n.excl = pwdata[CTRL_EXCL +: NLVL];
            end
            OFF_SEL: n.sel = pwdata;
            OFF_SPEC: n.maxspec = pwdata[SEQ_W-1:0];
            default: n.maxspec = s.maxspec;
         endcase
      end
      // Resolve or cancel
      if (acc_rs) begin
         if (rs.cancel) begin
            cancel_n = mod_sub(s.x, rs_map);
            n.x = rs_map;
         end else begin
            commit_n = mod_sub(rs_map, s.gamma);
            n.gamma = rs_map;
         end
      end
      // New block
      if (acc_blk) begin
         n.sample = res_in;
         n.ss = s_term && !stop_hit;
         n.tv = tv;
         n.pend = !traced && (s.pend || tv);
         if (traced) begin
            n.x = mod_inc(n.x);
            n.map[blk.tag] = n.x;
         end
      end
      // Software start/stop state wins over block update
      if (wr && paddr == OFF_CTRL) begin
         n.ss = pwdata[CTRL_SS];
      end
      // Reload table and sequence from committed indicator
      if (init_wr) begin
         for (int i = 0; i < NTAG; i++) begin
            n.map[i] = n.gamma;
         end
         n.x = n.gamma;
         n.pend = 1'b0;
      end
      // Block accepted only with room for one more speculative element
      n.rs_ready = space_next;
      n.blk_ready = space_next && (mod_sub(n.x, n.gamma) < n.maxspec);
   end

   // Element for trace generation, one per cycle at most
   always_comb begin
      push_d.blk = acc_blk && (tv || traced);
      push_d.p0 = acc_blk && traced;
      push_d.tag = blk.tag;
      push_d.commit_n = commit_n;
      push_d.cancel_n = cancel_n;
      push = push_d.blk || commit_n != 5'h00 || cancel_n != 5'h00;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.maxspec <= RST_SPEC;
         s.esel <= RST_CTRL[CTRL_ESEL +: 2];
         s.etype <= RST_CTRL[CTRL_ETYPE];
         s.excl <= RST_CTRL[CTRL_EXCL +: NLVL];
         s.sel <= RST_SEL;
      end else begin
         s <= n;
      end
   end

   // Element buffer towards trace generation
   tfsr_buf #(.W($bits(tfsr_elem_t))) u_buf (
      .clk(pclk),
      .rst_n(presetn),
      .in_valid(push),
      .in_data(push_d),
      .in_ready(),
      .space_next(space_next),
      .out_valid(elem_valid),
      .out_data(elem),
      .out_ready(elem_ready)
   );

   // Outputs
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign blk_ready = s.blk_ready;
   assign rs_ready = s.rs_ready;
   assign trace_view = s.tv;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_init;
      init_wr |=> (s.x == s.gamma) && (s.map[NTAG-1] == s.gamma);
   endproperty
   a_init: assert property (p_init) else $error("init did not load table");

   property p_adv;
      (acc_blk && traced && !acc_rs && !init_wr) |=> s.x == mod_inc($past(s.x));
   endproperty
   a_adv: assert property (p_adv) else $error("sequence not advanced");

   property p_commit;
      (acc_rs && !rs.cancel) |=> s.gamma == $past(rs_map);
   endproperty
   a_commit: assert property (p_commit) else $error("committed indicator wrong");

   property p_cancel;
      (acc_rs && rs.cancel && !acc_blk && !init_wr) |=> s.x == $past(rs_map);
   endproperty
   a_cancel: assert property (p_cancel) else $error("cancel did not rewind");

   property p_spec;
      (acc_blk && traced && !acc_rs) |-> mod_sub(s.x, s.gamma) < s.maxspec;
   endproperty
   a_spec: assert property (p_spec) else $error("speculation depth exceeded");

   property p_prohib;
      (acc_blk && (blk.prohibited || blk.debug)) |=> !trace_view;
   endproperty
   a_prohib: assert property (p_prohib) else $error("view high while prohibited");

   property p_whole;
      (acc_blk && tv) |=> elem_valid;
   endproperty
   a_whole: assert property (p_whole) else $error("viewed block not emitted");

   property p_sample;
      acc_blk |=> s.sample == $past(res_in);
   endproperty
   a_sample: assert property (p_sample) else $error("resource not sampled");

   property p_hold;
      !acc_blk |=> $stable(s.sample);
   endproperty
   a_hold: assert property (p_hold) else $error("resource sampled idle");

   property p_level;
      (acc_blk && blk.level < 3'd7 && s.excl[blk.level]) |=> !trace_view;
   endproperty
   a_level: assert property (p_level) else $error("excluded level viewed");

   sequence q_start;
      acc_blk && start_hit && !stop_hit && !(wr && paddr == OFF_CTRL);
   endsequence
   sequence q_stop;
      acc_blk && stop_hit && !(wr && paddr == OFF_CTRL);
   endsequence
   property p_ss;
      (q_start |=> s.ss) and (q_stop |=> !s.ss);
   endproperty
   a_ss: assert property (p_ss) else $error("start/stop state wrong");
endmodule

/* tb/tfsr_core_model.sv */
// Purpose: Core pipeline model offering blocks and resolves
// Assumes: Bench pulses a go line for one cycle per request
// Notes: Released lines show the inverse of their last value
`timescale 1ns/1ps
module tfsr_core_model
   import tfsr_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Requests from the bench
   input wire logic b_go,
   input wire tfsr_blk_t b_in,
   input wire logic r_go,
   input wire tfsr_rs_t r_in,
   // Core side of the block
   output logic blk_valid,
   output tfsr_blk_t blk,
   input wire logic blk_ready,
   output logic rs_valid,
   output tfsr_rs_t rs,
   input wire logic rs_ready
);
   // ---------------------------------------------------------------
   // Offers held until taken
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blk_valid <= 1'b0;
         blk <= '0;
         rs_valid <= 1'b0;
         rs <= '0;
      end else begin
         if (blk_valid && blk_ready) begin
            blk_valid <= 1'b0;
            blk <= ~blk;
         end else if (b_go && !blk_valid) begin
            blk_valid <= 1'b1;
            blk <= b_in;
         end
         if (rs_valid && rs_ready) begin
            rs_valid <= 1'b0;
            rs <= ~rs;
         end else if (r_go && !rs_valid) begin
            rs_valid <= 1'b1;
            rs <= r_in;
         end
      end
   end
endmodule

/* tb/tfsr_top_tb_top.sv */
// Purpose: Self-checking bench of resolver and view filter
// Assumes: Bench is APB master and element sink
// Notes: Popped elements are queued for comparison
`timescale 1ns/1ps
module tfsr_top_tb_top
   import tfsr_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic blk_valid, blk_ready, rs_valid, rs_ready, b_go, r_go, ok;
   logic elem_valid, elem_ready, trace_view;
   logic [NRES-1:0] res_in;
   tfsr_blk_t blk, b_in, b;
   tfsr_rs_t rs, r_in;
   tfsr_elem_t elem;
   tfsr_elem_t eq[$];
   int fail_count = 0;
   int n_checks = 0;
   tfsr_top tfsr_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .blk_valid, .blk, .res_in,
      .blk_ready, .rs_valid, .rs, .rs_ready, .elem_valid, .elem,
      .elem_ready, .trace_view);
   tfsr_core_model tfsr_core_model_i (.pclk, .presetn, .b_go, .b_in,
      .r_go, .r_in, .blk_valid, .blk, .blk_ready, .rs_valid, .rs,
      .rs_ready);
   // Clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // Capture popped elements
   always @(posedge pclk) begin
      if (elem_valid && elem_ready) eq.push_back(elem);
   end
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         $display("BAD t=%0t got %h exp %h", $time, g, e);
         fail_count++;
      end
   endtask
   task automatic lost();
      chk(32'h0, 32'h1);
      close_out();
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready) break;
      end
      if (k == 20) lost();
      rd = pslverr ? 32'hFFFF_FFFF : prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic take(input int lim);
      int k;
      ok = 1'b0;
      for (k = 0; k < lim && !ok; k++) begin
         @(posedge pclk);
         ok = blk_valid && blk_ready;
      end
   endtask
   task automatic sb(input tfsr_blk_t x, input int lim);
      @(posedge pclk);
      b_in <= x;
      b_go <= 1'b1;
      @(posedge pclk);
      b_go <= 1'b0;
      take(lim);
      if (!ok && lim == 40) lost();
   endtask
   task automatic sr(input logic c, input logic [2:0] t);
      int k;
      @(posedge pclk);
      r_in <= {c, t};
      r_go <= 1'b1;
      @(posedge pclk);
      r_go <= 1'b0;
      for (k = 0; k < 40; k++) begin
         @(posedge pclk);
         if (rs_valid && rs_ready) break;
      end
      if (k == 40) lost();
   endtask
   task automatic pop(input logic m, input logic [4:0] x, input logic [4:0] y);
      int k;
      tfsr_elem_t g;
      for (k = 0; k < 40 && eq.size() == 0; k++) @(posedge pclk);
      if (eq.size() == 0) lost();
      g = eq.pop_front();
      if (m) chk(32'({g.blk, g.p0, g.tag}), 32'({1'b1, x[3:0]}));
      else chk(32'({g.blk, g.commit_n, g.cancel_n}), 32'({1'b0, x, y}));
   endtask
   task automatic tv(input logic e);
      #1;
      chk(32'(trace_view), 32'(e));
   endtask
   function automatic tfsr_blk_t mk(input int t, input logic p, input int l);
      mk = '0;
      mk.tag = 3'(t);
      mk.has_p0 = p;
      mk.incl_ok = 1'b1;
      mk.level = 3'(l);
   endfunction
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic s_regs();
      apb(1'b0, OFF_SPEC, '0);
      chk(rd, 32'(RST_SPEC));
      apb(1'b0, OFF_SEL, '0);
      chk(rd, RST_SEL);
      apb(1'b1, OFF_STAT, 32'hFFFF_FFFF);
      apb(1'b0, OFF_STAT, '0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h10, '0);
      chk(rd, 32'hFFFF_FFFF);
   endtask
   task automatic s_spec();
      for (int i = 0; i < 4; i++) begin
         sb(mk(i, 1'b1, 4), 40);
         pop(1'b1, 5'(8 + i), 5'h0);
      end
      sr(1'b0, 3'h1);
      pop(1'b0, 5'h2, 5'h0);
      sr(1'b1, 3'h2);
      pop(1'b0, 5'h0, 5'h1);
      sb(mk(5, 1'b1, 4), 40);
      pop(1'b1, 5'hD, 5'h0);
      sr(1'b0, 3'h5);
      pop(1'b0, 5'h2, 5'h0);
      sb(mk(6, 1'b0, 4), 40);
      pop(1'b1, 5'h6, 5'h0);
      apb(1'b0, OFF_STAT, '0);
      chk(rd & 32'h1F1F, 32'h0404);
      for (int i = 0; i < 14; i++) begin
         sb(mk(i, 1'b1, 4), 40);
         pop(1'b1, 5'(8 + i % 8), 5'h0);
         sr(1'b0, 3'(i));
         pop(1'b0, 5'h1, 5'h0);
      end
      sb(mk(0, 1'b1, 4), 40);
      pop(1'b1, 5'h8, 5'h0);
      apb(1'b1, OFF_CTRL, 32'h3);
      apb(1'b0, OFF_STAT, '0);
      chk(rd & 32'h1F1F1F, 32'h0202);
      sr(1'b0, 3'h7);
      repeat (6) @(posedge pclk);
      chk(32'(eq.size()), 32'h0);
   endtask
   task automatic s_full();
      elem_ready <= 1'b0;
      for (int i = 0; i < 3; i++) sb(mk(i, 1'b0, 4), i < 2 ? 40 : 8);
      chk(32'(ok), 32'h0);
      elem_ready <= 1'b1;
      take(40);
      chk(32'(ok), 32'h1);
      for (int i = 0; i < 3; i++) pop(1'b1, 5'(i), 5'h0);
   endtask
   task automatic s_depth();
      apb(1'b1, OFF_SPEC, 32'h2);
      sb(mk(1, 1'b1, 4), 40);
      sb(mk(2, 1'b1, 4), 40);
      sb(mk(3, 1'b1, 4), 8);
      chk(32'(ok), 32'h0);
      sr(1'b0, 3'h2);
      take(40);
      chk(32'(ok), 32'h1);
      pop(1'b1, 5'h9, 5'h0);
      pop(1'b1, 5'hA, 5'h0);
      pop(1'b0, 5'h2, 5'h0);
      pop(1'b1, 5'hB, 5'h0);
      sr(1'b0, 3'h3);
      pop(1'b0, 5'h1, 5'h0);
      apb(1'b1, OFF_SPEC, 32'hF);
   endtask
   task automatic s_view();
      b = mk(0, 1'b0, 4);
      b.prohibited = 1'b1;
      sb(b, 40);
      tv(1'b0);
      b = mk(0, 1'b0, 4);
      b.debug = 1'b1;
      sb(b, 40);
      tv(1'b0);
      for (int i = 0; i < NLVL; i++) begin
         apb(1'b1, OFF_CTRL, 32'h2 | (32'h20 << i));
         sb(mk(0, 1'b0, i), 40);
         tv(1'b0);
         sb(mk(0, 1'b0, (i + 1) % NLVL), 40);
         tv(1'b1);
      end
      apb(1'b1, OFF_CTRL, 32'h16);
      res_in <= 4'h2;
      sb(mk(0, 1'b0, 4), 40);
      tv(1'b0);
      res_in <= 4'h3;
      sb(mk(0, 1'b0, 4), 40);
      tv(1'b1);
      res_in <= 4'hC;
      apb(1'b0, OFF_STAT, '0);
      chk(32'(rd[31:28]), 32'h3);
      apb(1'b1, OFF_CTRL, 32'h0);
      apb(1'b1, OFF_SEL, 32'h0200_0004);
      res_in <= 4'h1;
      b = mk(0, 1'b0, 4);
      b.sac_hit = 8'h08;
      sb(b, 40);
      tv(1'b0);
      b.sac_hit = 8'h04;
      sb(b, 40);
      tv(1'b1);
      b.sac_hit = 8'h00;
      b.pe_hit = 8'h02;
      sb(b, 40);
      tv(1'b1);
      b.pe_hit = 8'h00;
      sb(b, 40);
      tv(1'b0);
      eq.delete();
      sb(mk(1, 1'b1, 4), 40);
      tv(1'b0);
      pop(1'b1, 5'h9, 5'h0);
      sb(mk(2, 1'b1, 4), 40);
      repeat (4) @(posedge pclk);
      chk(32'(eq.size()), 32'h0);
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      res_in = 4'h1;
      elem_ready = 1'b1;
      b_go = 1'b0;
      r_go = 1'b0;
      b_in = '0;
      r_in = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      s_regs();
      apb(1'b1, OFF_CTRL, 32'h2);
      s_spec();
      s_full();
      s_depth();
      s_view();
      close_out();
   end
endmodule
